// ==== failsafe_status.sv ====
// Module: fail-safe input pairing, monitoring and status word five
`timescale 1ns/1ps
module failsafe_status #(
    parameter int TOL_CYCLES = failsafe_pkg::TOL_CYCLES_DEFAULT
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [failsafe_pkg::NUM_INPUTS-1:0] digital_input,
    input wire failsafe_pkg::variant_e variant,
    input wire logic pairs_commissioned,
    input wire logic fault_clear,
    input wire logic [failsafe_pkg::WORD_W-1:0] safety_control_word_five,
    output logic [failsafe_pkg::WORD_W-1:0] safety_status_word_five,
    output logic [failsafe_pkg::NUM_INPUTS-1:0] standard_input,
    output logic [failsafe_pkg::NUM_PAIRS-1:0] safe_pair_active,
    output logic [failsafe_pkg::NUM_PAIRS-1:0] safe_pair_fault,
    output logic control_word_error
);
    import failsafe_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] sync1_q, sync2_q;   // Two-stage pin capture
    logic commissioned_q, commissioned_d;      // Pairing latched in
    variant_e variant_q, variant_d;            // Variant captured at commissioning
    logic [NUM_PAIRS-1:0] used;                // Pairs in use
    pair_state_s pair_st [NUM_PAIRS];          // Monitor results
    logic [NUM_PAIRS-1:0] pair_bit;            // Reported pair level
    logic [WORD_W-1:0] status_d, status_q;
    logic [NUM_INPUTS-1:0] std_d, std_q;
    logic ctrl_err_d, ctrl_err_q;
    logic [NUM_INPUTS-1:0] pa, pb;             // Channels routed per pair slot

    localparam logic [TOL_W-1:0] TOL_LOAD = TOL_W'(TOL_CYCLES);

    // Synchroniser: first stage read only by the second
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= digital_input;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Pair assignment
    // ------------------------------------------------------------
    // Which pair slots a variant uses
    function automatic logic [NUM_PAIRS-1:0] pairs_for(input variant_e v);
        case (v)
            VARIANT_MULTI_EXT: pairs_for = 3'b111;
            default: pairs_for = 3'b001;
        endcase
    endfunction

    // Commissioning state; variant frozen so pairing cannot shift live
    always_comb begin
        commissioned_d = pairs_commissioned;
        variant_d = variant_q;
        if (pairs_commissioned && !commissioned_q) begin
            variant_d = variant;
        end
    end

    // Route channels: extended maps 0/1,2/3,4/5; others map 4/5 to slot 0
    always_comb begin
        used = commissioned_q ? pairs_for(variant_q) : '0;
        pa = '0;
        pb = '0;
        if (variant_q == VARIANT_MULTI_EXT) begin
            pa[0] = sync2_q[0];
            pb[0] = sync2_q[1];
            pa[1] = sync2_q[2];
            pb[1] = sync2_q[3];
            pa[2] = sync2_q[4];
            pb[2] = sync2_q[5];
        end else begin
            pa[0] = sync2_q[4];
            pb[0] = sync2_q[5];
        end
    end

    // Per-pair monitors
    for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
        pair_monitor #(.TOL_W(TOL_W)) u_mon (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .chan_a(pa[i]),
            .chan_b(pb[i]),
            .pair_used(used[i]),
            .tol_cycles(TOL_LOAD),
            .fault_clear(fault_clear),
            .state(pair_st[i])
        );
        // Zero when unused or disabled
        assign pair_bit[i] = used[i] && !pair_st[i].disabled && pair_st[i].level;
        assign safe_pair_active[i] = used[i];
        assign safe_pair_fault[i] = pair_st[i].disabled;
    end

    // ------------------------------------------------------------
    // Status word five and standard inputs
    // ------------------------------------------------------------
    // Latency from a pin edge to the status word, counted in clock edges:
    //   two edges through the synchroniser,
    //   one edge into the separate channel paths of the monitor,
    //   one edge into the agreed level,
    //   one edge into the status register.
    // A controller polling the word therefore sees a pin change about
    // five cycles late; this is far below any telegram cycle, so no
    // effort is spent on shortening it.
    // Status bit positions follow the physical pins, not the slot index
    always_comb begin
        status_d = STAT_RESET;
        std_d = sync2_q;
        if (variant_q == VARIANT_MULTI_EXT) begin
            status_d[STAT_PAIR_0_BIT] = pair_bit[0];
            status_d[STAT_PAIR_1_BIT] = pair_bit[1];
            status_d[STAT_PAIR_2_BIT] = pair_bit[2];
        end else begin
            status_d[STAT_PAIR_2_BIT] = pair_bit[0];
        end
        // Paired pins are no longer standard inputs
        if (used[0] && variant_q != VARIANT_MULTI_EXT) begin
            std_d[5:4] = 2'b00;
        end
        if (variant_q == VARIANT_MULTI_EXT) begin
            if (used[0]) std_d[1:0] = 2'b00;
            if (used[1]) std_d[3:2] = 2'b00;
            if (used[2]) std_d[5:4] = 2'b00;
        end
        // Reserved control bits must arrive zero; flag otherwise
        ctrl_err_d = (safety_control_word_five != CTRL_RESERVED_VALUE);
    end

    // Output and state registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            commissioned_q <= 1'b0;
            variant_q <= VARIANT_SINGLE;
            status_q <= STAT_RESET;
            std_q <= '0;
            ctrl_err_q <= 1'b0;
        end else begin
            commissioned_q <= commissioned_d;
            variant_q <= variant_d;
            status_q <= status_d;
            std_q <= std_d;
            ctrl_err_q <= ctrl_err_d;
        end
    end

    assign safety_status_word_five = status_q;
    assign standard_input = std_q;
    assign control_word_error = ctrl_err_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (status_q[7:0] == 8'h00) && (status_q[15:11] == 5'h00))
        else $error("reserved status bit set");
    factory_nopair_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !commissioned_q |=> status_q == STAT_RESET)
        else $error("status set without commissioning");
    ext_bit8_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT) |=> status_q[STAT_PAIR_0_BIT] == $past(pair_bit[0]))
        else $error("bit 8 wrong");
    ext_bit9_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT) |=> status_q[STAT_PAIR_1_BIT] == $past(pair_bit[1]))
        else $error("bit 9 wrong");
    single_bit10_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q != VARIANT_MULTI_EXT) |=> status_q[STAT_PAIR_2_BIT] == $past(pair_bit[0]))
        else $error("bit 10 wrong");
    fault_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pair_st[0].disabled |=> !status_q[STAT_PAIR_2_BIT] || variant_q == VARIANT_MULTI_EXT)
        else $error("disabled pair reported high");
    unused_zero_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !used[1] |=> !status_q[STAT_PAIR_1_BIT])
        else $error("unused pair reported high");
    ctrl_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (safety_control_word_five != CTRL_RESERVED_VALUE) |=> control_word_error)
        else $error("nonzero control word not flagged");
    sel_path_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (commissioned_q && variant_q != VARIANT_MULTI_EXT && !pair_st[0].disabled
         && sync2_q[5:4] == 2'b11) |-> ##3 (status_q[STAT_PAIR_2_BIT]
         || $past(pair_st[0].disabled) || !commissioned_q || pair_st[0].disabled))
        else $error("both high not reported");

    // Extended variant: pins 4/5 land in bit 10 from slot 2
    ext_bit10_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT) |=> status_q[STAT_PAIR_2_BIT] == $past(pair_bit[2]))
        else $error("bit 10 wrong in extended variant");

    // A disabled slot must never show high in its status bit
    fault_slot0_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT && pair_st[0].disabled) |=> !status_q[STAT_PAIR_0_BIT])
        else $error("disabled slot 0 reported high");

    // Same for slot 1 on pins 2/3
    fault_slot1_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT && pair_st[1].disabled) |=> !status_q[STAT_PAIR_1_BIT])
        else $error("disabled slot 1 reported high");

    // Same for slot 2 on pins 4/5
    fault_slot2_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT && pair_st[2].disabled) |=> !status_q[STAT_PAIR_2_BIT])
        else $error("disabled slot 2 reported high");

    // Non-extended variants report slot 0 in bit 10
    fault_single_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q != VARIANT_MULTI_EXT && pair_st[0].disabled) |=> !status_q[STAT_PAIR_2_BIT])
        else $error("disabled single pair reported high");

    // Paired pins 4/5 stop reading as standard inputs
    std_single_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (used[0] && variant_q != VARIANT_MULTI_EXT) |=> standard_input[5:4] == 2'b00)
        else $error("paired pins still standard");

    // Extended variant takes pins 2/3 out of the standard set
    std_ext_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (variant_q == VARIANT_MULTI_EXT && used[1]) |=> standard_input[3:2] == 2'b00)
        else $error("pins 2/3 still standard");

    // Before commissioning no slot is active
    active_none_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !commissioned_q |-> safe_pair_active == 3'b000)
        else $error("pair active without commissioning");

    // Before commissioning every pin passes through as a standard input
    std_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !commissioned_q |=> standard_input == $past(sync2_q))
        else $error("standard input not following pin");

    // Extended variant activates all three slots
    active_ext_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (commissioned_q && variant_q == VARIANT_MULTI_EXT) |-> safe_pair_active == 3'b111)
        else $error("extended variant slots wrong");

    // Other variants activate slot 0 only
    active_basic_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (commissioned_q && variant_q != VARIANT_MULTI_EXT) |-> safe_pair_active == 3'b001)
        else $error("single variant slots wrong");

    // Variant stays frozen while commissioning holds
    variant_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (commissioned_q && pairs_commissioned) |=> variant_q == $past(variant_q))
        else $error("variant changed while commissioned");

    // A zero control word leaves the flag low
    ctrl_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (safety_control_word_five == CTRL_RESERVED_VALUE) |=> !control_word_error)
        else $error("zero control word flagged");

    // An unused slot drops its fault history
    unused_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !used[2] |=> !safe_pair_fault[2])
        else $error("unused slot kept fault");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_ext_c: cover property (@(posedge core_clk) status_q[10:8] == 3'b111);
    cov_fault_c: cover property (@(posedge core_clk) safe_pair_fault[0]);
    cov_single_c: cover property (@(posedge core_clk)
        variant_q == VARIANT_SINGLE && status_q[STAT_PAIR_2_BIT]);
    // Re-arm after a discrepancy
    cov_clear_c: cover property (@(posedge core_clk) $fell(safe_pair_fault[1]));
    // Misbehaving controller seen
    cov_ctrl_c: cover property (@(posedge core_clk) control_word_error);
endmodule

// ==== failsafe_pkg.sv ====
// Package: constants and carrier types for the fail-safe input status block
package failsafe_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int NUM_INPUTS = 6;        // Digital input pins
    localparam int NUM_PAIRS = 3;         // Fail-safe pairs at most
    localparam int WORD_W = 16;           // Telegram word width
    localparam int TELEGRAM_ID = 900;     // Telegram carrying status word five

    // ------------------------------------------------------------
    // Status word field positions
    // ------------------------------------------------------------
    localparam int STAT_PAIR_0_BIT = 8;   // Level of pins 0/1
    localparam int STAT_PAIR_1_BIT = 9;   // Level of pins 2/3
    localparam int STAT_PAIR_2_BIT = 10;  // Level of pins 4/5
    localparam logic [WORD_W-1:0] STAT_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] CTRL_RESERVED_VALUE = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;          // 250 MHz core clock
    localparam int TOL_TIME_US_DEFAULT = 500;     // Tolerance time, microseconds
    localparam int TOL_CYCLES_DEFAULT = (TOL_TIME_US_DEFAULT * 1000000) / CLK_PERIOD_PS;
    localparam int TOL_W = 24;                    // Width of tolerance counter

    // ------------------------------------------------------------
    // Pairing variants
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VARIANT_SINGLE,      // One pair: pins 4/5 as pair 0
        VARIANT_MULTI_BASIC, // Several pairs, basic: pins 4/5 as pair 0
        VARIANT_MULTI_EXT    // Several pairs, extended: 0/1, 2/3, 4/5
    } variant_e;

    // Per-pair evaluation result
    typedef struct packed {
        logic level;       // Agreed level of both channels
        logic disabled;    // Deactivated by discrepancy
    } pair_state_s;

endpackage

// ==== pair_monitor.sv ====
// Module: two-channel discrepancy monitor for one fail-safe input pair
`timescale 1ns/1ps
module pair_monitor #(
    parameter int TOL_W = 24
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic chan_a,               // Synchronised channel A
    input wire logic chan_b,               // Synchronised channel B
    input wire logic pair_used,            // Pair configured for use
    input wire logic [TOL_W-1:0] tol_cycles,
    input wire logic fault_clear,          // Re-arm after discrepancy
    output failsafe_pkg::pair_state_s state
);
    import failsafe_pkg::*;

    // ------------------------------------------------------------
    // Separate evaluation paths
    // ------------------------------------------------------------
    logic path_a_q, path_a_d;              // Channel A judgement
    logic path_b_q, path_b_d;              // Channel B judgement
    logic [TOL_W-1:0] mism_cnt_q, mism_cnt_d;
    logic disabled_q, disabled_d;
    logic level_q, level_d;

    // Next-state logic
    always_comb begin
        path_a_d = chan_a;
        path_b_d = chan_b;
        mism_cnt_d = mism_cnt_q;
        disabled_d = disabled_q;
        level_d = level_q;
        if (!pair_used) begin
            // Unused pair holds no fault history
            mism_cnt_d = '0;
            disabled_d = 1'b0;
            level_d = 1'b0;
        end else if (path_a_q != path_b_q) begin
            // Mismatch: cable break or bad sensor suspected
            if (mism_cnt_q >= tol_cycles) begin
                disabled_d = 1'b1;
            end else begin
                mism_cnt_d = mism_cnt_q + 1'b1;
            end
        end else begin
            // Channels agree; level follows them only while they do and holds during a mismatch
            mism_cnt_d = '0;
            level_d = path_a_q;
            // Re-arm only on agreement so a live fault cannot be hidden
            if (fault_clear) begin
                disabled_d = 1'b0;
            end
        end
    end

    // Registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            path_a_q <= 1'b0;
            path_b_q <= 1'b0;
            mism_cnt_q <= '0;
            disabled_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            path_a_q <= path_a_d;
            path_b_q <= path_b_d;
            mism_cnt_q <= mism_cnt_d;
            disabled_q <= disabled_d;
            level_q <= level_d;
        end
    end

    assign state.level = level_q;
    assign state.disabled = disabled_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    mism_disable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (pair_used && path_a_q != path_b_q && mism_cnt_q >= tol_cycles) |=> disabled_q)
        else $error("pair not disabled after tolerance");
    early_disable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!disabled_q && mism_cnt_q < tol_cycles) |=> !disabled_q || $past(pair_used) == 1'b0)
        else $error("pair disabled before tolerance");
    unused_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !pair_used |=> (!disabled_q && !level_q))
        else $error("unused pair kept state");
endmodule

// ==== sensor_model.sv ====
// Partner model: two-channel safety sensors and the safety controller's control word
`timescale 1ns/1ps
module sensor_model (
    input wire logic core_clk,
    input wire logic [failsafe_pkg::NUM_PAIRS-1:0] pair_level,   // Wanted contact level per pair
    input wire logic [failsafe_pkg::NUM_PAIRS-1:0] chan_b_break, // Commanded fault on channel B
    input wire logic [failsafe_pkg::WORD_W-1:0] ctrl_value,      // Commanded control word
    output logic [failsafe_pkg::NUM_INPUTS-1:0] digital_input = 6'h00,
    output logic [failsafe_pkg::WORD_W-1:0] safety_control_word_five = 16'h0000
);
    import failsafe_pkg::*;

    // ------------------------------------------------------------
    // Contact levels
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] pins_d; // Next pin levels

    // Both channels follow one contact; a break flips channel B only
    always_comb begin
        for (int p = 0; p < NUM_PAIRS; p++) begin
            pins_d[2*p] = pair_level[p];
            pins_d[2*p+1] = pair_level[p] ^ chan_b_break[p];
        end
    end

    // Switch just after the edge, as a relay seen through the sync flops would
    always @(posedge core_clk) begin
        digital_input <= pins_d;
        safety_control_word_five <= ctrl_value;
    end
endmodule

// ==== testbench.sv ====
// Testbench: random and corner-case checks of the fail-safe status word
`timescale 1ns/1ps
module testbench;
    import failsafe_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int TOL = 8; // Short tolerance keeps discrepancy runs brief
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    variant_e variant = VARIANT_SINGLE;
    variant_e mode_v = VARIANT_SINGLE; // Variant the design should have captured
    logic pairs_commissioned = 1'b0;
    logic fault_clear = 1'b0;
    logic [NUM_PAIRS-1:0] lvl = 3'h0; // Commanded pair levels
    logic [NUM_PAIRS-1:0] brk = 3'h0; // Commanded channel B breaks
    logic [WORD_W-1:0] ctrl = 16'h0000; // Commanded control word
    logic [NUM_INPUTS-1:0] digital_input;
    logic [WORD_W-1:0] safety_control_word_five;
    logic [WORD_W-1:0] safety_status_word_five;
    logic [NUM_INPUTS-1:0] standard_input;
    logic [NUM_PAIRS-1:0] safe_pair_active;
    logic [NUM_PAIRS-1:0] safe_pair_fault;
    logic control_word_error;
    int bad_count = 0;
    int check_count = 0;
    variant_e vtab [3] = '{VARIANT_MULTI_EXT, VARIANT_SINGLE, VARIANT_MULTI_BASIC};

    sensor_model partner (.core_clk(core_clk), .pair_level(lvl), .chan_b_break(brk),
        .ctrl_value(ctrl), .digital_input(digital_input),
        .safety_control_word_five(safety_control_word_five));

    failsafe_status #(.TOL_CYCLES(TOL)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .digital_input(digital_input), .variant(variant),
        .pairs_commissioned(pairs_commissioned), .fault_clear(fault_clear),
        .safety_control_word_five(safety_control_word_five),
        .safety_status_word_five(safety_status_word_five), .standard_input(standard_input),
        .safe_pair_active(safe_pair_active), .safe_pair_fault(safe_pair_fault),
        .control_word_error(control_word_error));

    // 250 MHz core clock
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Expected word: non-extended variants report pins 4/5 in bit 10
    function automatic logic [WORD_W-1:0] exp_word(logic comm, variant_e v,
        logic [2:0] l, logic [2:0] f);
        logic [WORD_W-1:0] w;
        w = STAT_RESET;
        if (comm && v == VARIANT_MULTI_EXT) begin
            w[STAT_PAIR_0_BIT] = l[0] & ~f[0];
            w[STAT_PAIR_1_BIT] = l[1] & ~f[1];
        end
        if (comm) w[STAT_PAIR_2_BIT] = l[2] & ~f[2];
        return w;
    endfunction

    // Pins taken into pairs stop reading as standard inputs
    function automatic logic [NUM_INPUTS-1:0] paired(logic comm, variant_e v);
        if (!comm) return 6'h00;
        return (v == VARIANT_MULTI_EXT) ? 6'h3F : 6'h30;
    endfunction

    task automatic cmp(logic [WORD_W-1:0] got, logic [WORD_W-1:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Faults are given per pin pair; slots shift for the non-extended variants
    task automatic verify(logic [2:0] f);
        logic [NUM_INPUTS-1:0] pins;
        logic [NUM_PAIRS-1:0] slot_f;
        logic [NUM_PAIRS-1:0] act;
        for (int p = 0; p < NUM_PAIRS; p++) pins[2*p +: 2] = {lvl[p] ^ brk[p], lvl[p]};
        slot_f = (mode_v == VARIANT_MULTI_EXT) ? f : {2'b00, f[2]};
        act = (mode_v == VARIANT_MULTI_EXT) ? 3'h7 : 3'h1;
        if (!pairs_commissioned) slot_f = 3'h0;
        if (!pairs_commissioned) act = 3'h0;
        cmp(safety_status_word_five, exp_word(pairs_commissioned, mode_v, lvl, f),
            "status word");
        cmp(WORD_W'(standard_input), WORD_W'(pins & ~paired(pairs_commissioned, mode_v)),
            "standard inputs");
        cmp(WORD_W'(safe_pair_active), WORD_W'(act), "active pairs");
        cmp(WORD_W'(safe_pair_fault), WORD_W'(slot_f), "pair faults");
    endtask

    task automatic set_mode(logic comm, variant_e v);
        pairs_commissioned <= 1'b0;
        tick(3);
        variant <= v;
        mode_v <= v;
        pairs_commissioned <= comm;
        tick(12);
    endtask

    task automatic apply(logic [2:0] l, logic [2:0] b, int wait_n);
        lvl <= l;
        brk <= b;
        tick(wait_n);
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(11));
        tick(20);
        reset_n <= 1'b1;
        tick(2);
        // Factory state: inputs stay standard, no pair in use
        apply(3'h5, 3'h0, 12);
        verify(3'h0);
        // Random levels across every pairing variant
        for (int i = 0; i < 24; i++) begin
            set_mode(1'b1, vtab[i % 3]);
            apply(3'($urandom), 3'h0, 12);
            verify(3'h0);
        end
        // Variant change while commissioned must be ignored
        set_mode(1'b1, VARIANT_SINGLE);
        variant <= VARIANT_MULTI_EXT;
        apply(3'h7, 3'h0, 12);
        verify(3'h0);
        // Short mismatch tolerated, long one disables, clear re-arms
        set_mode(1'b1, VARIANT_MULTI_EXT);
        for (int p = 0; p < NUM_PAIRS; p++) begin
            apply(3'h7, 3'(1 << p), TOL / 2);
            apply(3'h7, 3'h0, 12);
            verify(3'h0);
            apply(3'h7, 3'(1 << p), 4 * TOL);
            verify(3'(1 << p));
            apply(3'h7, 3'h0, 12);
            verify(3'(1 << p));
            fault_clear <= 1'b1;
            tick(3);
            fault_clear <= 1'b0;
            tick(12);
            verify(3'h0);
        end
        // Single variant: discrepancy on pins 4/5 disables slot 0
        set_mode(1'b1, VARIANT_SINGLE);
        apply(3'h7, 3'h4, 4 * TOL);
        verify(3'h4);
        // Clear refused while the mismatch is still live
        fault_clear <= 1'b1;
        tick(3);
        fault_clear <= 1'b0;
        tick(12);
        verify(3'h4);
        // Reserved control bits set by a misbehaving controller
        ctrl <= 16'h8001;
        tick(4);
        cmp(WORD_W'(control_word_error), 16'h0001, "control word flag");
        ctrl <= 16'h0000;
        tick(4);
        cmp(WORD_W'(control_word_error), 16'h0000, "control word flag");
        wrap_up();
    end

    // Hang guard: the sequence needs only about a thousand cycles
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule
